// *** rtl/su_core.sv ***
// su_core.sv: serial unit, asynchronous and clocked modes, APB registers
// assumes: APB master on pclk; pins are joined to pads outside
`timescale 1ns/100ps
module su_core (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial pins
  input wire logic rx_line_pin,
  output logic tx_line_out,
  output logic tx_line_oe,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  // system
  input wire logic sub_clock_mode,
  output logic rx_fault_irq
);
  // ********************
  // state
  // ********************
  typedef struct packed {
    su_pkg::su_tx_t tx;
    su_pkg::su_rx_t rx;
    logic [3:0] tcnt;
    logic [3:0] rcnt;
    logic [3:0] tbit;
    logic [3:0] rbit;
    logic [7:0] tx_buffer_word;
    logic [7:0] tx_shift_word;
    logic [7:0] rsr;
    logic [7:0] rx_buffer_word;
    logic tpar, rpar;
    logic tx_buffer_empty_flag, rx_buffer_full_flag, overrun_fault_flag, framing_fault_flag, per;
    logic [7:0] ctl;
    logic [7:0] baud;
    logic [1:0] port;
    logic tx_bit, sck_lvl, sck_prev, ck_drive;
    logic [31:0] rdata;
    logic txd, txoe, ckd, ckoe, irq;
  } su_core_t;
  su_core_t s;
  su_core_t next_s;

  function automatic logic su_mapped(input logic [7:0] a);
    su_mapped = (a == su_pkg::ADDR_CTL) || (a == su_pkg::ADDR_BAUD) ||
      (a == su_pkg::ADDR_FLAG) || (a == su_pkg::ADDR_TXB) ||
      (a == su_pkg::ADDR_RXB) || (a == su_pkg::ADDR_PORT);
  endfunction : su_mapped

  logic [1:0] pin_s;
  logic rx_s, sck_s, tick, run;
  logic te, re, sync_on, ext, par_on, err;
  logic wr_ok, rd_ok, keep_full, fin, fin_ok, fin_pbad;
  logic ev_samp, ev_shift, rise, fall, load;
  logic [3:0] tlast, rlast;

  // ********************
  // pins and pulses
  // ********************
  su_sync2 u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({sck_in, rx_line_pin}),
    .q(pin_s)
  );
  assign rx_s = pin_s[0];
  assign sck_s = pin_s[1];

  // sub clock mode stalls the basic clock unless divider bit set
  assign run = (te || re) &&
    !(sub_clock_mode && !s.ctl[su_pkg::CTL_SUBDIV]);
  su_tick u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .div(s.baud),
    .run(run),
    .tick(tick)
  );

  assign te = s.ctl[su_pkg::CTL_TE];
  assign re = s.ctl[su_pkg::CTL_RE];
  assign sync_on = s.ctl[su_pkg::CTL_SYNC];
  assign ext = sync_on && s.ctl[su_pkg::CTL_CKHI];
  assign par_on = s.ctl[su_pkg::CTL_PAR] && !sync_on;
  assign err = s.overrun_fault_flag || s.framing_fault_flag || s.per;
  assign wr_ok = psel && penable && pwrite;
  assign rd_ok = psel && penable && !pwrite;
  assign keep_full = s.rx_buffer_full_flag && !(rd_ok && paddr == su_pkg::ADDR_RXB);
  assign rise = sck_s && !s.sck_prev;
  assign fall = !sck_s && s.sck_prev;
  // sample mid-bit at the eighth basic pulse
  assign ev_samp = ext ? rise : (tick && s.tcnt == su_pkg::PH_SAMPLE);
  assign ev_shift = ext ? fall : (tick && s.tcnt == su_pkg::PH_LAST);
  assign tlast = par_on ? su_pkg::BIT_PLAST : su_pkg::BIT_DLAST;
  assign rlast = tlast;
  assign load = te && !s.tx_buffer_empty_flag;

  // ********************
  // next state
  // ********************
  always_comb begin
    next_s = s;
    fin = 1'b0;
    fin_ok = 1'b1;
    fin_pbad = 1'b0;
    next_s.sck_prev = sck_s;
    // transmitter, and clocked-mode frame engine
    if (s.tx != su_pkg::TX_IDLE && tick) begin
      next_s.tcnt = s.tcnt + 4'h1;
    end
    case (s.tx)
      su_pkg::TX_IDLE: begin
        next_s.tcnt = 4'h0;
        next_s.tbit = 4'h0;
        if (sync_on) begin
          // receive faults block a clocked start
          if (!err && (load || (re && !te))) begin
            next_s.tx = su_pkg::TX_DATA;
            next_s.tx_shift_word = load ? s.tx_buffer_word : 8'hFF;
            next_s.tx_bit = load ? s.tx_buffer_word[0] : 1'b1;
            // move to shifter sets empty flag
            next_s.tx_buffer_empty_flag = s.tx_buffer_empty_flag || load;
          end
        end else if (load) begin
          next_s.tx = su_pkg::TX_START;
          next_s.tx_shift_word = s.tx_buffer_word;
          next_s.tpar = ^s.tx_buffer_word;
          next_s.tx_bit = 1'b0;
          next_s.tx_buffer_empty_flag = 1'b1;
        end
      end
      su_pkg::TX_START: begin
        if (ev_shift) begin
          next_s.tx = su_pkg::TX_DATA;
          next_s.tx_bit = s.tx_shift_word[0];
        end
      end
      su_pkg::TX_DATA: begin
        if (sync_on && re && ev_samp) begin
          next_s.rsr = {rx_s, s.rsr[7:1]};
        end
        if (ev_shift) begin
          if (sync_on && s.tbit == su_pkg::BIT_DLAST) begin
            next_s.tx = su_pkg::TX_IDLE;
            fin = re;
          end else if (s.tbit == tlast) begin
            next_s.tx = su_pkg::TX_STOP;
            next_s.tx_bit = 1'b1;
          end else begin
            next_s.tbit = s.tbit + 4'h1;
            next_s.tx_shift_word = {1'b1, s.tx_shift_word[7:1]};
            next_s.tx_bit = (s.tbit == su_pkg::BIT_DLAST) ? s.tpar :
              s.tx_shift_word[1];
          end
        end
      end
      su_pkg::TX_STOP: begin
        if (ev_shift) begin
          next_s.tx = su_pkg::TX_IDLE;
        end
      end
      default: begin
        next_s.tx = su_pkg::TX_IDLE;
      end
    endcase
    // transmit disable drops any frame in flight, except in clocked mode with receive enabled
    if (!te && !(sync_on && re)) begin
      next_s.tx = su_pkg::TX_IDLE;
      next_s.tx_bit = 1'b1;
    end
    // asynchronous receiver; level low after idle is the start edge
    if (s.rx != su_pkg::RX_IDLE && tick) begin
      next_s.rcnt = s.rcnt + 4'h1;
    end
    case (s.rx)
      su_pkg::RX_IDLE: begin
        next_s.rcnt = 4'h0;
        next_s.rbit = 4'h0;
        // a held break restarts a frame at once
        if (tick && !rx_s) begin
          next_s.rx = su_pkg::RX_START;
        end
      end
      su_pkg::RX_START: begin
        if (tick && s.rcnt == su_pkg::PH_SAMPLE) begin
          next_s.rx = rx_s ? su_pkg::RX_IDLE : su_pkg::RX_DATA;
        end
      end
      su_pkg::RX_DATA: begin
        if (tick && s.rcnt == su_pkg::PH_SAMPLE) begin
          if (s.rbit == su_pkg::BIT_PLAST) begin
            next_s.rpar = rx_s;
          end else begin
            next_s.rsr = {rx_s, s.rsr[7:1]};
          end
          if (s.rbit == rlast) begin
            next_s.rx = su_pkg::RX_STOP;
          end else begin
            next_s.rbit = s.rbit + 4'h1;
          end
        end
      end
      su_pkg::RX_STOP: begin
        if (tick && s.rcnt == su_pkg::PH_SAMPLE) begin
          next_s.rx = su_pkg::RX_IDLE;
          fin = 1'b1;
          fin_ok = rx_s;
          fin_pbad = par_on && ((^s.rsr) != s.rpar);
        end
      end
      default: begin
        next_s.rx = su_pkg::RX_IDLE;
      end
    endcase
    // receiver off stops framing, flags stay
    if (!re || sync_on) begin
      next_s.rx = su_pkg::RX_IDLE;
    end
    // register writes
    if (wr_ok) begin
      if (paddr == su_pkg::ADDR_CTL) begin
        next_s.ctl = pwdata[7:0];
      end else if (paddr == su_pkg::ADDR_BAUD) begin
        next_s.baud = pwdata[7:0];
      end else if (paddr == su_pkg::ADDR_PORT) begin
        next_s.port = pwdata[1:0];
      end else if (paddr == su_pkg::ADDR_FLAG) begin
        // fault flags clear by writing zero to them
        next_s.overrun_fault_flag = s.overrun_fault_flag && pwdata[su_pkg::FL_OER];
        next_s.framing_fault_flag = s.framing_fault_flag && pwdata[su_pkg::FL_FER];
        next_s.per = s.per && pwdata[su_pkg::FL_PER];
      end else if (paddr == su_pkg::ADDR_TXB) begin
        // always accepted, may overwrite an unmoved word
        next_s.tx_buffer_word = pwdata[7:0];
        next_s.tx_buffer_empty_flag = 1'b0;
      end
    end
    // buffer read clears the full flag
    if (rd_ok && paddr == su_pkg::ADDR_RXB) begin
      next_s.rx_buffer_full_flag = 1'b0;
    end
    // frame end; applied last so a set beats any clear
    if (fin) begin
      // still full at frame end means overrun
      if (keep_full) begin
        next_s.overrun_fault_flag = 1'b1;
      end else begin
        next_s.rx_buffer_word = s.rsr;
        next_s.rx_buffer_full_flag = 1'b1;
        // stop bit low sets framing fault
        next_s.framing_fault_flag = s.framing_fault_flag || !fin_ok;
        next_s.per = s.per || fin_pbad;
      end
    end
    // read data captured in setup so prdata comes from a flop
    if (psel && !penable) begin
      if (paddr == su_pkg::ADDR_CTL) begin
        next_s.rdata = {24'h000000, s.ctl};
      end else if (paddr == su_pkg::ADDR_BAUD) begin
        next_s.rdata = {24'h000000, s.baud};
      end else if (paddr == su_pkg::ADDR_FLAG) begin
        next_s.rdata = {27'h0000000, s.per, s.framing_fault_flag, s.overrun_fault_flag, s.rx_buffer_full_flag, s.tx_buffer_empty_flag};
      end else if (paddr == su_pkg::ADDR_TXB) begin
        next_s.rdata = {24'h000000, s.tx_buffer_word};
      end else if (paddr == su_pkg::ADDR_RXB) begin
        next_s.rdata = {24'h000000, s.rx_buffer_word};
      end else if (paddr == su_pkg::ADDR_PORT) begin
        next_s.rdata = {30'h00000000, s.port};
      end else begin
        next_s.rdata = 32'h00000000;
      end
    end
    // pins, from the values that take effect this edge
    // port direction and level own the pin while off
    next_s.txd = next_s.ctl[su_pkg::CTL_TE] ? next_s.tx_bit :
      next_s.port[su_pkg::PORT_LVL];
    next_s.txoe = next_s.ctl[su_pkg::CTL_TE] ||
      next_s.port[su_pkg::PORT_DIR];
    next_s.ck_drive = next_s.ctl[su_pkg::CTL_SYNC] &&
      !next_s.ctl[su_pkg::CTL_CKHI];
    // internal clock low for the first half of each bit
    next_s.sck_lvl = !(next_s.tx == su_pkg::TX_DATA && !next_s.tcnt[3]);
    // one-clock low pulse when clock out turns to port use
    next_s.ckoe = next_s.ck_drive || (s.ck_drive &&
      !next_s.ctl[su_pkg::CTL_SYNC] && !next_s.ctl[su_pkg::CTL_CKHI] &&
      !next_s.ctl[su_pkg::CTL_CKLO]);
    next_s.ckd = next_s.ck_drive && next_s.sck_lvl;
    next_s.irq = next_s.ctl[su_pkg::CTL_RIE] &&
      (next_s.overrun_fault_flag || next_s.framing_fault_flag || next_s.per);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.tx <= su_pkg::TX_IDLE;
      s.rx <= su_pkg::RX_IDLE;
      s.tx_buffer_empty_flag <= 1'b1;
      s.ctl <= su_pkg::CTL_RST;
      s.baud <= su_pkg::BAUD_RST;
      s.port <= su_pkg::PORT_RST;
      s.tx_bit <= 1'b1;
      s.sck_lvl <= 1'b1;
      s.sck_prev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ********************
  // outputs
  // ********************
  assign prdata = s.rdata;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !su_mapped(paddr);
  assign tx_line_out = s.txd;
  assign tx_line_oe = s.txoe;
  assign sck_out = s.ckd;
  assign sck_oe = s.ckoe;
  assign rx_fault_irq = s.irq;

  // ********************
  // checks
  // ********************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_break_sets_fer: assert property (fin && !fin_ok && !keep_full |=>
    s.framing_fault_flag && s.rx_buffer_full_flag) else $error("break did not set framing fault");
  a_port_fallback: assert property (!te |-> tx_line_oe ==
    s.port[su_pkg::PORT_DIR] && tx_line_out == s.port[su_pkg::PORT_LVL])
    else $error("transmit pin not handed to port");
  a_tx_reset_now: assert property ($fell(te) && !(sync_on && re) |=>
    s.tx == su_pkg::TX_IDLE) else $error("transmitter not reset");
  a_sync_err_hold: assert property (sync_on && err &&
    s.tx == su_pkg::TX_IDLE |=> s.tx == su_pkg::TX_IDLE)
    else $error("clocked start with fault set");
  a_flag_keep: assert property (s.overrun_fault_flag && !(wr_ok &&
    paddr == su_pkg::ADDR_FLAG) |=> s.overrun_fault_flag) else $error("overrun flag lost");
  a_mid_sample: assert property (s.rx == su_pkg::RX_START && tick &&
    s.rcnt == su_pkg::PH_SAMPLE && !rx_s && re && !sync_on |=>
    s.rx == su_pkg::RX_DATA && s.rbit == 4'h0)
    else $error("start bit not taken mid-bit");
  a_glitch_low: assert property ($fell(s.ck_drive) &&
    !s.ctl[su_pkg::CTL_CKHI] && !s.ctl[su_pkg::CTL_CKLO] |->
    sck_oe && !sck_out ##1 !sck_oe)
    else $error("clock pin switch pulse wrong");
  a_tx_buffer_empty_flag_clear: assert property (wr_ok && paddr == su_pkg::ADDR_TXB |=>
    !s.tx_buffer_empty_flag && s.tx_buffer_word == $past(pwdata[7:0]))
    else $error("buffer write left empty flag");
  a_overrun_keep: assert property (fin && keep_full |=>
    s.overrun_fault_flag && $stable(s.rx_buffer_word)) else $error("overrun not flagged");
  a_read_clear: assert property (rd_ok && paddr == su_pkg::ADDR_RXB &&
    !fin |=> !s.rx_buffer_full_flag) else $error("read did not clear full");
  a_fault_irq: assert property ($rose(s.framing_fault_flag) &&
    s.ctl[su_pkg::CTL_RIE] |-> rx_fault_irq)
    else $error("fault request missing");
endmodule : su_core

// *** rtl/su_pkg.sv ***
// su_pkg.sv: offsets, field positions, reset values and state codes
// assumes: one APB slave on pclk (25 MHz), 32-bit data, byte addresses
// How it works
// - a break on the receive line sets the framing fault, never parity
// - receiver keeps running in a break, so a cleared framing fault returns once the receive buffer is read
// - transmit disabled hands the transmit pin to port direction and level
// - clearing transmit enable resets the transmitter at once, except in clocked mode with receive enabled
// - clocked mode never starts a transfer while a receive fault is set
// - disabling the receiver leaves the three fault flags untouched
// - asynchronous timing comes from a basic clock at sixteen times bit rate
// - start edge found on the basic clock, bits taken at eighth pulse
// - clock pin switched from clock out to port use drives low briefly
// - buffer write clears the empty flag; move to shifter sets it
// - buffer writes always accepted; an unmoved word is overwritten
// - a frame ending while the full flag is set reports overrun
// - reading the receive buffer clears the full flag; set wins
// - low power mode runs the unit only with the sub clock divider set or on an external clock in clocked mode
// - any fault flag with receive interrupts on raises the fault request
package su_pkg;
  // ********************
  // register map
  // ********************
  localparam logic [7:0] ADDR_CTL = 8'h00;
  localparam logic [7:0] ADDR_BAUD = 8'h04;
  localparam logic [7:0] ADDR_FLAG = 8'h08;
  localparam logic [7:0] ADDR_TXB = 8'h0C;
  localparam logic [7:0] ADDR_RXB = 8'h10;
  localparam logic [7:0] ADDR_PORT = 8'h14;
  // control bits
  localparam int CTL_TE = 0;
  localparam int CTL_RE = 1;
  localparam int CTL_SYNC = 2;
  localparam int CTL_CKHI = 3;
  localparam int CTL_CKLO = 4;
  localparam int CTL_RIE = 5;
  localparam int CTL_PAR = 6;
  localparam int CTL_SUBDIV = 7;
  // flag bits
  localparam int FL_TX_BUFFER_EMPTY_FLAG = 0;
  localparam int FL_RX_BUFFER_FULL_FLAG = 1;
  localparam int FL_OER = 2;
  localparam int FL_FER = 3;
  localparam int FL_PER = 4;
  // port bits
  localparam int PORT_DIR = 0;
  localparam int PORT_LVL = 1;
  // reset values
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [1:0] PORT_RST = 2'h0;
  // ********************
  // bit timing
  // ********************
  localparam logic [3:0] PH_SAMPLE = 4'h7;
  localparam logic [3:0] PH_LAST = 4'hF;
  localparam logic [3:0] BIT_DLAST = 4'h7;
  localparam logic [3:0] BIT_PLAST = 4'h8;
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA = 4'b0100,
    TX_STOP = 4'b1000
  } su_tx_t;
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } su_rx_t;
endpackage : su_pkg

// *** rtl/su_sync2.sv ***
// su_sync2.sv: two-flop synchroniser for the line and clock pins
// assumes: inputs are asynchronous to pclk
`timescale 1ns/100ps
module su_sync2 (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // levels
  input wire logic [1:0] d,
  output logic [1:0] q
);
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
  } su_sy_t;
  su_sy_t s;
  su_sy_t next_s;
  always_comb begin
    next_s = s;
    next_s.s1 = d;
    next_s.s2 = s.s1;
  end
  // idle lines are high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '1;
    end else begin
      s <= next_s;
    end
  end
  assign q = s.s2;
endmodule : su_sync2

// *** rtl/su_tick.sv ***
// su_tick.sv: basic clock pulse generator
// assumes: div is a software rate setting, stable while running
`timescale 1ns/100ps
module su_tick (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic [7:0] div,
  input wire logic run,
  // pulse
  output logic tick
);
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } su_tk_t;
  su_tk_t s;
  su_tk_t next_s;
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!run) begin
      next_s.cnt = 8'h00;
    end else if (s.cnt == div) begin
      next_s.cnt = 8'h00;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 8'h01;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign tick = s.tick;
endmodule : su_tick

// *** sim/su_remote.sv ***
// su_remote.sv: remote serial station on the two data lines
// assumes: one bit lasts BIT pclk cycles, 8 data bits, no parity
`timescale 1ns/100ps
module su_remote #(
  parameter int BIT = 16
) (
  // clock
  input wire logic pclk,
  // line from the block
  input wire logic tx_wire,
  // line to the block
  output logic rx_line,
  // received word
  output logic [7:0] got,
  output logic got_ok
);
  // ********************
  // station
  // ********************
  logic [8:0] rs;
  logic prev;
  int rc;
  initial begin
    rx_line = 1'b1;
    got = 8'h00;
    got_ok = 1'b0;
    rs = 9'h000;
    prev = 1'b1;
    rc = 0;
  end
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      rx_line <= f[i];
      repeat (BIT - 1) @(posedge pclk);
    end
  endtask : send
  task automatic hold_low(input int n);
    @(posedge pclk);
    rx_line <= 1'b0;
    repeat (n) @(posedge pclk);
    rx_line <= 1'b1;
  endtask : hold_low
  // falling edge, mid-bit sample; a low stop drops the frame
  always @(posedge pclk) begin
    got_ok <= 1'b0;
    prev <= tx_wire;
    if (rc == 0) begin
      if (prev === 1'b1 && tx_wire === 1'b0) rc <= 1;
    end else if (rc == 9 * BIT + BIT / 2 + 1) begin
      got <= rs[7:0];
      got_ok <= rs[8];
      rc <= 0;
    end else begin
      rc <= rc + 1;
      if (rc % BIT == BIT / 2 && rc > BIT) rs <= {tx_wire, rs[8:1]};
    end
  end
endmodule : su_remote

// *** sim/su_core_tb.sv ***
// su_core_tb.sv: self-checking bench for the serial unit
// assumes: su_pkg, su_core and su_remote are compiled first
`timescale 1ns/100ps
module su_core_tb;
  // ********************
  // bench
  // ********************
  localparam logic [7:0] A_CTL = su_pkg::ADDR_CTL;
  localparam logic [7:0] A_FLAG = su_pkg::ADDR_FLAG;
  localparam logic [31:0] C_TX = 32'h1 << su_pkg::CTL_TE;
  localparam logic [31:0] C_RX = 32'h1 << su_pkg::CTL_RE;
  localparam logic [31:0] C_SY = 32'h1 << su_pkg::CTL_SYNC;
  localparam logic [31:0] C_CK = 32'h1 << su_pkg::CTL_CKHI;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, got, b0, b2;
  logic [31:0] pwdata, prdata, r, seed;
  logic rx_line_pin, tx_line_out, tx_line_oe, tx_wire, sck_out, sck_oe;
  logic rx_fault_irq, got_ok, q, sub_mode;
  logic [65:0] e;
  logic [65:0] expq[$];
  logic [7:0] txq[$];
  int n_fail, checked, g;
  // nobody drives: the line is pulled up
  assign tx_wire = tx_line_oe ? tx_line_out : 1'b1;
  su_core u_su_core (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_line_pin(rx_line_pin), .tx_line_out(tx_line_out),
    .tx_line_oe(tx_line_oe), .sck_in(1'b0), .sck_out(sck_out),
    .sck_oe(sck_oe), .sub_clock_mode(sub_mode),
    .rx_fault_irq(rx_fault_irq));
  su_remote #(.BIT(16)) u_su_remote (.pclk(pclk), .tx_wire(tx_wire),
    .rx_line(rx_line_pin), .got(got), .got_ok(got_ok));
  function automatic logic [32:0] fb(input int n);
    return 33'h1 << n;
  endfunction : fb
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs
  task automatic chk(input string what, input logic [32:0] x,
                     input logic [32:0] s);
    checked++;
    if (s !== x) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, x, s);
    end
  endtask : chk
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [32:0] m,
                    input logic [32:0] v);
    expq.push_back({m, v});
    apb(a, 1'b0, 32'h0);
  endtask : rd
  // bounded wait on one flag bit
  task automatic poll(input int b, input logic v);
    int i;
    for (i = 0; i < 150; i++) begin
      rd(A_FLAG, 33'h0, 33'h0);
      if (r[b] === v) break;
    end
    chk("flag poll", 33'h1, 33'(i < 150));
  endtask : poll
  task automatic test_done();
    $display("counts: checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  // monitor: oldest note against each read and each frame
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = expq.pop_front();
      if (e[65:33] != 33'h0)
        chk("apb read", e[32:0], {pslverr, prdata} & e[65:33]);
    end
    if (got_ok === 1'b1) begin
      if (txq.size() == 0) chk("frame", 33'h0, fb(32) | 33'(got));
      else chk("frame", 33'(txq.pop_front()), 33'(got));
    end
  end
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    test_done();
  end
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_fail = 0;
    checked = 0;
    seed = 32'h6914;
    sub_mode = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk("tx oe", 33'h0, 33'(tx_line_oe));
    rd(A_CTL, 33'hFF, 33'h0);
    rd(A_FLAG, 33'h1F, fb(su_pkg::FL_TX_BUFFER_EMPTY_FLAG));
    rd(8'h40, 33'h1_FFFF_FFFF, fb(32));
    $display("test reset done");
    seed = xs(seed);
    b0 = seed[7:0];
    seed = xs(seed);
    b2 = seed[7:0];
    txq.push_back(b0);
    txq.push_back(b2);
    wr(su_pkg::ADDR_BAUD, 32'h0);
    wr(A_CTL, C_TX | C_RX | (32'h1 << su_pkg::CTL_RIE));
    wr(su_pkg::ADDR_TXB, 32'(b0));
    wr(su_pkg::ADDR_TXB, 32'(~b2));
    wr(su_pkg::ADDR_TXB, 32'(b2));
    rd(A_FLAG, fb(su_pkg::FL_TX_BUFFER_EMPTY_FLAG), 33'h0);
    poll(su_pkg::FL_TX_BUFFER_EMPTY_FLAG, 1'b1);
    for (int i = 0; i < 400 && txq.size() > 0; i++) @(posedge pclk);
    chk("frames left", 33'h0, 33'(txq.size()));
    $display("test transmit done");
    seed = xs(seed);
    b0 = seed[7:0];
    u_su_remote.send(b0);
    poll(su_pkg::FL_RX_BUFFER_FULL_FLAG, 1'b1);
    u_su_remote.send(~b0);
    poll(su_pkg::FL_OER, 1'b1);
    chk("fault irq", 33'h1, 33'(rx_fault_irq));
    rd(su_pkg::ADDR_RXB, 33'hFF, 33'(b0));
    rd(A_FLAG, fb(su_pkg::FL_RX_BUFFER_FULL_FLAG), 33'h0);
    wr(A_CTL, C_TX | (32'h1 << su_pkg::CTL_RIE));
    rd(A_FLAG, fb(su_pkg::FL_OER), fb(su_pkg::FL_OER));
    wr(A_FLAG, 32'h0);
    rd(A_FLAG, 33'h1C, 33'h0);
    chk("fault irq", 33'h0, 33'(rx_fault_irq));
    $display("test receive done");
    wr(A_CTL, C_RX);
    fork
      u_su_remote.hold_low(640);
      begin
        poll(su_pkg::FL_FER, 1'b1);
        wr(A_FLAG, 32'h0);
        rd(A_FLAG, fb(su_pkg::FL_FER), 33'h0);
        // empty the buffer, else the next break frame is an overrun
        rd(su_pkg::ADDR_RXB, 33'hFF, 33'h0);
        poll(su_pkg::FL_FER, 1'b1);
      end
    join
    $display("test break done");
    wr(A_CTL, C_TX);
    wr(su_pkg::ADDR_PORT, 32'h1);
    wr(su_pkg::ADDR_TXB, 32'h0);
    poll(su_pkg::FL_TX_BUFFER_EMPTY_FLAG, 1'b1);
    wr(A_CTL, 32'h0);
    g = 0;
    repeat (200) begin
      @(posedge pclk);
      #1;
      if (tx_line_oe !== 1'b1 || tx_line_out !== 1'b0) g++;
    end
    chk("break held", 33'h0, 33'(g));
    wr(su_pkg::ADDR_PORT, 32'h3);
    @(posedge pclk);
    #1;
    chk("mark", 33'h3, 33'({tx_line_oe, tx_line_out}));
    wr(su_pkg::ADDR_PORT, 32'h0);
    @(posedge pclk);
    #1;
    chk("port input", 33'h0, 33'(tx_line_oe));
    wr(A_CTL, C_TX);
    g = 0;
    repeat (100) begin
      @(posedge pclk);
      #1;
      if (tx_wire !== 1'b1) g++;
    end
    chk("idle after abort", 33'h0, 33'(g));
    $display("test port done");
    // faults from the break are still set
    wr(A_CTL, C_TX | (32'h1 << su_pkg::CTL_SYNC));
    wr(su_pkg::ADDR_TXB, 32'hFF);
    g = 0;
    q = sck_out;
    repeat (64) begin
      @(posedge pclk);
      if (sck_out !== q) g++;
      q = sck_out;
    end
    chk("held clock", 33'h0, 33'(g));
    rd(A_FLAG, fb(su_pkg::FL_TX_BUFFER_EMPTY_FLAG), 33'h0);
    wr(A_FLAG, 32'h0);
    poll(su_pkg::FL_TX_BUFFER_EMPTY_FLAG, 1'b1);
    wr(A_CTL, 32'h0);
    g = 0;
    repeat (4) begin
      #1;
      if (sck_oe === 1'b1 && sck_out === 1'b0) g++;
      @(posedge pclk);
    end
    chk("clock pin low", 33'h1, 33'(g != 0));
    chk("clock pin off", 33'h0, 33'(sck_oe));
    // clean stop: drop the clock drive first, keep clocked mode
    wr(A_CTL, C_TX | C_SY);
    wr(su_pkg::ADDR_TXB, 32'hFF);
    wr(A_CTL, C_SY | C_CK);
    g = 0;
    fork
      begin
        wr(A_CTL, C_CK);
        wr(A_CTL, 32'h0);
      end
      repeat (12) begin
        #1;
        if (sck_oe !== 1'b0) g++;
        @(posedge pclk);
      end
    join
    chk("clean clock stop", 33'h0, 33'(g));
    $display("test clocked done");
    rd(su_pkg::ADDR_RXB, 33'hFF, 33'h0);
    // unit idle before the power state changes
    sub_mode <= 1'b1;
    wr(A_CTL, C_RX);
    seed = xs(seed);
    b0 = seed[7:0];
    u_su_remote.send(b0);
    rd(A_FLAG, fb(su_pkg::FL_RX_BUFFER_FULL_FLAG), 33'h0);
    wr(A_CTL, C_RX | (32'h1 << su_pkg::CTL_SUBDIV));
    u_su_remote.send(~b0);
    poll(su_pkg::FL_RX_BUFFER_FULL_FLAG, 1'b1);
    rd(su_pkg::ADDR_RXB, 33'hFF, 33'(b0 ^ 8'hFF));
    $display("test sub clock done");
    test_done();
  end
endmodule : su_core_tb
